// ==== hdl/esf_consts.svh ====
// Offsets, field positions, reset values and sizes of the SRAM/FIFO block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef ESF_CONSTS_SVH
`define ESF_CONSTS_SVH
// Register byte offsets on the APB side
`define ESF_OFF_CTRL   12'h000
`define ESF_OFF_AE_THR 12'h004
`define ESF_OFF_AF_THR 12'h008
`define ESF_OFF_STAT   12'h00C
`define ESF_OFF_INT    12'h010
`define ESF_OFF_MASK   12'h014
// Control register fields
`define ESF_CTRL_FIFO  0
`define ESF_CTRL_PIPE  1
`define ESF_CTRL_WW    4:2
`define ESF_CTRL_RW    7:5
// Reset values
`define ESF_CTRL_RST   8'h00
`define ESF_AE_RST     13'h0004
`define ESF_AF_RST     13'h00FC
// Array geometry: 256 words of 18 bits, 4,608 bits in all
`define ESF_TOTAL_BITS 4608
`define ESF_WORDS      256
`define ESF_WBITS      18
// Interrupt status bit count
`define ESF_NINT       7
`endif

// ==== hdl/esf_fifo_ctrl.sv ====
// Pointer counters and status flags of the embedded FIFO.
// Assumes the array depth for each width is a power of two.
`timescale 1ns/1ns
`include "esf_consts.svh"
module esf_fifo_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Towards the top level
  esf_fifo_if.ctrl f
);
  esf_pkg::esf_cnt_t wr_ptr_reg; // Write pointer, wraps at 2^13
  esf_pkg::esf_cnt_t rd_ptr_reg; // Read pointer
  esf_pkg::esf_cnt_t count_next; // Count after this cycle
  esf_pkg::esf_cnt_t depth;      // Elements at current width

  assign depth     = esf_pkg::esf_depth(f.width);
  // Requests against a full or empty FIFO are dropped
  assign f.push_ok = f.push & ~f.full;
  assign f.pop_ok  = f.pop & ~f.empty;
  assign f.wr_addr = wr_ptr_reg[11:0] & (depth[11:0] - 12'h001);
  assign f.rd_addr = rd_ptr_reg[11:0] & (depth[11:0] - 12'h001);
  assign count_next = f.count + {12'h000, f.push_ok} - {12'h000, f.pop_ok};

  // Pointer counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      f.count    <= '0;
    end else if (f.clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      f.count    <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + {12'h000, f.push_ok};
      rd_ptr_reg <= rd_ptr_reg + {12'h000, f.pop_ok};
      f.count    <= count_next;
    end
  end

  // Flags follow the count of the next cycle, so they are never late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f.empty <= 1'b1;
      f.full  <= 1'b0;
      f.ae    <= 1'b1;
      f.af    <= 1'b0;
    end else if (f.clear) begin
      f.empty <= 1'b1;
      f.full  <= 1'b0;
      f.ae    <= 1'b1;
      f.af    <= 1'b0;
    end else begin
      f.empty <= (count_next == 13'h0000);
      f.full  <= (count_next == depth);
      f.ae    <= (count_next <= f.ae_thr);
      f.af    <= (count_next >= f.af_thr);
    end
  end
endmodule

// ==== hdl/esf_fifo_if.sv ====
// Carrier between the top level and the FIFO pointer controller.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface esf_fifo_if;
  logic                push;     // Push request
  logic                pop;      // Pop request
  logic                clear;    // Pointer reset; pulse, held outside FIFO mode
  esf_pkg::esf_width_t width;    // FIFO element width
  esf_pkg::esf_cnt_t   ae_thr;   // Almost-empty threshold
  esf_pkg::esf_cnt_t   af_thr;   // Almost-full threshold
  logic [11:0]         wr_addr;  // Element index to write
  logic [11:0]         rd_addr;  // Element index to read
  esf_pkg::esf_cnt_t   count;    // Stored elements
  logic                full;
  logic                empty;
  logic                ae;
  logic                af;
  logic                push_ok;  // Push accepted this cycle
  logic                pop_ok;   // Pop accepted this cycle
  modport ctrl (input push, pop, clear, width, ae_thr, af_thr,
                output wr_addr, rd_addr, count, full, empty, ae, af, push_ok, pop_ok);
  modport user (output push, pop, clear, width, ae_thr, af_thr,
                input wr_addr, rd_addr, count, full, empty, ae, af, push_ok, pop_ok);
endinterface

// ==== hdl/esf_pkg.sv ====
// Types and helpers shared by the SRAM/FIFO block.
// Assumes nothing of its surroundings.
package esf_pkg;
  // Port width selection; codes 5..7 behave as 18 bits
  typedef enum logic [2:0] {ESF_W1, ESF_W2, ESF_W4, ESF_W9, ESF_W18} esf_width_t;
  typedef logic [17:0] esf_word_t;
  typedef logic [12:0] esf_cnt_t;
  // Location of one element inside the 18-bit word array
  typedef struct packed {
    logic [7:0] word;
    logic [4:0] off;
    esf_word_t  mask;
  } esf_loc_t;

  // Element count for a width; all are powers of two
  function automatic esf_cnt_t esf_depth(input esf_width_t w);
    case (w)
      ESF_W1:  esf_depth = 13'h1000;
      ESF_W2:  esf_depth = 13'h0800;
      ESF_W4:  esf_depth = 13'h0400;
      ESF_W9:  esf_depth = 13'h0200;
      default: esf_depth = 13'h0100;
    endcase
  endfunction

  // Narrow widths use the low 16 bits of a word; 9 uses both halves
  function automatic esf_loc_t esf_map(input logic [11:0] a, input esf_width_t w);
    esf_loc_t l;
    l = '0;
    case (w)
      ESF_W1: begin
        l.word = a[11:4];
        l.off  = {1'b0, a[3:0]};
        l.mask = 18'h00001;
      end
      ESF_W2: begin
        l.word = a[10:3];
        l.off  = {1'b0, a[2:0], 1'b0};
        l.mask = 18'h00003;
      end
      ESF_W4: begin
        l.word = a[9:2];
        l.off  = {1'b0, a[1:0], 2'b00};
        l.mask = 18'h0000F;
      end
      ESF_W9: begin
        l.word = a[8:1];
        l.off  = a[0] ? 5'h09 : 5'h00;
        l.mask = 18'h001FF;
      end
      default: begin
        l.word = a[7:0];
        l.off  = 5'h00;
        l.mask = 18'h3FFFF;
      end
    endcase
    return l;
  endfunction
endpackage

// ==== hdl/esf_sram.sv ====
// Word array with masked write and a one- or two-stage read register.
// Assumes one clock for both ports; contents are not reset.
`timescale 1ns/1ns
module esf_sram #(
  parameter int W  = 18,
  parameter int N  = 256,
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [W-1:0]  wr_mask,
  // Read port
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  input  wire logic [4:0]    rd_off,
  input  wire logic [W-1:0]  rd_mask,
  input  wire logic          pipe,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [N];   // Storage
  logic [W-1:0] stage_reg; // First read stage for pipelined mode
  logic [W-1:0] ext;       // Selected element, right aligned

  assign ext = (mem[rd_addr] >> rd_off) & rd_mask;

  // Masked write keeps the other elements that share the word
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // Read registers: one edge when plain, two edges when pipelined
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= '0;
      rd_data   <= '0;
    end else begin
      if (rd_en) begin
        stage_reg <= ext;
      end
      if (pipe) begin
        rd_data <= stage_reg;
      end else if (rd_en) begin
        rd_data <= ext;
      end
    end
  end
endmodule

// ==== hdl/esf_top.sv ====
// Embedded 4,608-bit SRAM with FIFO controller, APB registers and serial loader.
// Assumes user ports come from logic on pclk; loader pins are asynchronous.
// Operation
// - 4,608 bits, aspect ratio set by configuration
// - 256x18, 512x9, 1kx4, 2kx2, 4kx1 organisations
// - Read and write widths chosen independently in RAM mode
// - Plain read: data after one read edge
// - Pipelined read: data after second read edge
// - Write stores only while write enable high
// - Built-in FIFO controller, programmable width, depth
// - Controller counters generate read, write pointers
// - Empty, full, almost-empty, almost-full flags
// - Contents loadable serially at initialisation
// - Loader selects block, shifts all 4,608 bits
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "esf_consts.svh"
module esf_top (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // User write port
  input  wire logic        wen,
  input  wire logic [11:0] waddr,
  input  wire logic [17:0] wdata,
  // User read port
  input  wire logic        ren,
  input  wire logic [11:0] read_address_bus,
  output logic      [17:0] rdata,
  // FIFO status
  output logic             fifo_empty,
  output logic             fifo_full,
  output logic             almost_empty_flag,
  output logic             almost_full_flag,
  // Serial loader pins from the user test port macro
  input  wire logic        load_select,
  input  wire logic        load_clk,
  input  wire logic        load_data,
  output logic             load_busy,
  // Interrupt
  output logic             irq
);
  esf_fifo_if fif ();                           // Link to FIFO controller

  logic [7:0]            ctrl_reg;              // Mode and widths
  esf_pkg::esf_cnt_t     ae_thr_reg;            // Almost-empty threshold
  esf_pkg::esf_cnt_t     af_thr_reg;            // Almost-full threshold
  logic [`ESF_NINT-1:0]  int_stat_reg;          // Sticky events
  logic [`ESF_NINT-1:0]  int_mask_reg;          // Event enables
  logic [`ESF_NINT-1:0]  int_ev;                // Events this cycle
  logic [`ESF_NINT-1:0]  int_w1c;               // Bits cleared by software
  logic [3:0]            flag_d_reg;            // Flags one cycle ago
  logic                  fifo_mode;
  esf_pkg::esf_width_t   wr_width;
  esf_pkg::esf_width_t   rd_width;
  esf_pkg::esf_loc_t     wloc;                  // Write location
  esf_pkg::esf_loc_t     rloc;                  // Read location
  logic                  apb_wr;                // Write takes effect
  logic                  addr_ok;               // Mapped register
  logic [31:0]           rd_mux;                // Register read value
  logic                  clear_reg;             // FIFO pointer reset
  logic [2:0]            pin_s1_reg;            // Synchroniser stage one
  logic [2:0]            pin_s2_reg;            // Synchroniser stage two
  logic                  lclk_d_reg;            // Loader clock, delayed
  logic                  lsel_d_reg;            // Loader select, delayed
  logic [17:0]           ld_shift_reg;          // Bits gathered so far
  logic [4:0]            ld_bit_reg;            // Bit within word
  logic [7:0]            ld_word_reg;           // Word being loaded
  logic                  ld_wr_reg;             // Loader write strobe
  logic [7:0]            ld_addr_reg;           // Loader write word
  logic [17:0]           ld_data_reg;           // Loader write data
  logic                  ld_done;               // Last word written
  logic                  lclk_rise;
  logic                  lsel_rise;
  logic                  user_block;            // Loader owns the array
  logic                  mem_wr;
  logic [7:0]            mem_waddr;
  logic [17:0]           mem_wdata;
  logic [17:0]           mem_wmask;
  logic                  mem_rd;

  // Configuration fields; FIFO mode uses the write width for both ports
  assign fifo_mode = ctrl_reg[`ESF_CTRL_FIFO];
  assign wr_width  = esf_pkg::esf_width_t'(ctrl_reg[`ESF_CTRL_WW]);
  assign rd_width  = esf_pkg::esf_width_t'(ctrl_reg[`ESF_CTRL_RW]);

  // ---------------- APB slave ----------------
  assign apb_wr  = psel & penable & pwrite & pready;
  assign addr_ok = (paddr == `ESF_OFF_CTRL)   || (paddr == `ESF_OFF_AE_THR) ||
                   (paddr == `ESF_OFF_AF_THR) || (paddr == `ESF_OFF_STAT)   ||
                   (paddr == `ESF_OFF_INT)    || (paddr == `ESF_OFF_MASK);

  // Read value of the addressed register; unmapped reads as zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      `ESF_OFF_CTRL:   rd_mux = {24'h000000, ctrl_reg};
      `ESF_OFF_AE_THR: rd_mux = {19'h00000, ae_thr_reg};
      `ESF_OFF_AF_THR: rd_mux = {19'h00000, af_thr_reg};
      `ESF_OFF_STAT:   rd_mux = {11'h000, fif.count, 3'h0, load_busy,
                                 fif.af, fif.ae, fif.full, fif.empty};
      `ESF_OFF_INT:    rd_mux = {25'h0000000, int_stat_reg};
      `ESF_OFF_MASK:   rd_mux = {25'h0000000, int_mask_reg};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // One wait-free access phase: answer prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~addr_ok;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Configuration registers; a control write restarts the FIFO
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= `ESF_CTRL_RST;
      ae_thr_reg <= `ESF_AE_RST;
      af_thr_reg <= `ESF_AF_RST;
      int_mask_reg <= '0;
      clear_reg  <= 1'b1;
    end else begin
      clear_reg <= apb_wr && (paddr == `ESF_OFF_CTRL);
      if (apb_wr) begin
        case (paddr)
          `ESF_OFF_CTRL:   ctrl_reg   <= pwdata[7:0];
          `ESF_OFF_AE_THR: ae_thr_reg <= pwdata[12:0];
          `ESF_OFF_AF_THR: af_thr_reg <= pwdata[12:0];
          `ESF_OFF_MASK:   int_mask_reg <= pwdata[`ESF_NINT-1:0];
          default:         ;
        endcase
      end
    end
  end

  // ---------------- Interrupts ----------------
  assign int_ev  = {ld_done,
                    fifo_mode & ren & fif.empty,
                    fifo_mode & wen & ~user_block & fif.full,
                    fif.af & ~flag_d_reg[3],
                    fif.ae & ~flag_d_reg[2],
                    fif.full & ~flag_d_reg[1],
                    fif.empty & ~flag_d_reg[0]};
  assign int_w1c = (apb_wr && (paddr == `ESF_OFF_INT)) ? pwdata[`ESF_NINT-1:0] : '0;

  // Sticky status: an event in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= '0;
      flag_d_reg   <= 4'h5;  // Reset levels of af, ae, full, empty: no false rise
      irq          <= 1'b0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~int_w1c) | int_ev;
      flag_d_reg   <= {fif.af, fif.ae, fif.full, fif.empty};
      irq          <= |(int_stat_reg & int_mask_reg);
    end
  end

  // ---------------- Serial loader ----------------
  // Pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
      lclk_d_reg <= 1'b0;
      lsel_d_reg <= 1'b0;
    end else begin
      pin_s1_reg <= {load_data, load_clk, load_select};
      pin_s2_reg <= pin_s1_reg;
      lclk_d_reg <= pin_s2_reg[1];
      lsel_d_reg <= pin_s2_reg[0];
    end
  end

  assign lclk_rise  = pin_s2_reg[1] & ~lclk_d_reg;
  assign lsel_rise  = pin_s2_reg[0] & ~lsel_d_reg;
  assign user_block = pin_s2_reg[0] | ld_wr_reg;
  assign ld_done    = ld_wr_reg & (ld_addr_reg == 8'(`ESF_WORDS - 1));

  // Bits arrive first-bit-most-significant, 18 to a word, 256 words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_shift_reg <= '0;
      ld_bit_reg   <= '0;
      ld_word_reg  <= '0;
      ld_wr_reg    <= 1'b0;
      ld_addr_reg  <= '0;
      ld_data_reg  <= '0;
      load_busy    <= 1'b0;
    end else begin
      ld_wr_reg <= 1'b0;
      if (lsel_rise) begin
        ld_bit_reg  <= '0;
        ld_word_reg <= '0;
        load_busy   <= 1'b1;
      end else if (!pin_s2_reg[0]) begin
        load_busy <= 1'b0;
      end else if (load_busy && lclk_rise) begin
        ld_shift_reg <= {ld_shift_reg[16:0], pin_s2_reg[2]};
        if (ld_bit_reg == 5'(`ESF_WBITS - 1)) begin
          ld_bit_reg  <= '0;
          ld_wr_reg   <= 1'b1;
          ld_addr_reg <= ld_word_reg;
          ld_data_reg <= {ld_shift_reg[16:0], pin_s2_reg[2]};
          ld_word_reg <= ld_word_reg + 8'h01;
          if (ld_word_reg == 8'(`ESF_WORDS - 1)) begin
            load_busy <= 1'b0;
          end
        end else begin
          ld_bit_reg <= ld_bit_reg + 5'h01;
        end
      end
    end
  end

  // ---------------- FIFO controller ----------------
  assign fif.push   = fifo_mode & wen & ~user_block;
  assign fif.pop    = fifo_mode & ren;
  assign fif.clear  = clear_reg | ~fifo_mode;
  assign fif.width  = wr_width;
  assign fif.ae_thr = ae_thr_reg;
  assign fif.af_thr = af_thr_reg;

  esf_fifo_ctrl u_fifo (
    .clk   (pclk),
    .rst_n (presetn),
    .f     (fif)
  );

  // ---------------- Array access ----------------
  // FIFO mode reads at the FIFO width so pushed elements come back whole
  assign wloc = esf_pkg::esf_map(fifo_mode ? fif.wr_addr : waddr, wr_width);
  assign rloc = esf_pkg::esf_map(fifo_mode ? fif.rd_addr : read_address_bus,
                                 fifo_mode ? wr_width : rd_width);
  assign mem_rd = fifo_mode ? fif.pop_ok : ren;

  // Loader writes win; user writes need the enable high
  always_comb begin
    mem_wr    = 1'b0;
    mem_waddr = wloc.word;
    mem_wdata = (wdata << wloc.off) & wloc.mask << wloc.off;
    mem_wmask = wloc.mask << wloc.off;
    if (ld_wr_reg) begin
      mem_wr    = 1'b1;
      mem_waddr = ld_addr_reg;
      mem_wdata = ld_data_reg;
      mem_wmask = 18'h3FFFF;
    end else if (fifo_mode) begin
      mem_wr = fif.push_ok;
    end else begin
      mem_wr = wen & ~user_block;
    end
  end

  esf_sram #(
    .W  (`ESF_WBITS),
    .N  (`ESF_WORDS),
    .AW (8)
  ) u_sram (
    .clk     (pclk),
    .rst_n   (presetn),
    .wr_en   (mem_wr),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .wr_mask (mem_wmask),
    .rd_en   (mem_rd),
    .rd_addr (rloc.word),
    .rd_off  (rloc.off),
    .rd_mask (rloc.mask),
    .pipe    (ctrl_reg[`ESF_CTRL_PIPE]),
    .rd_data (rdata)
  );

  // Status outputs come from the controller's flag flops
  assign fifo_empty        = fif.empty;
  assign fifo_full         = fif.full;
  assign almost_empty_flag = fif.ae;
  assign almost_full_flag  = fif.af;
endmodule

// ==== verification/esf_checker.sv ====
// Handshake and flag assertions for the SRAM/FIFO top level.
// Assumes it is bound to esf_top and sees only its ports.
`timescale 1ns/1ns
module esf_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // User side, flags and loader
  input wire logic wen,
  input wire logic ren,
  input wire logic fifo_empty,
  input wire logic fifo_full,
  input wire logic almost_empty_flag,
  input wire logic almost_full_flag,
  input wire logic load_select,
  input wire logic load_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup phase of a transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  // No register write now or one cycle back, so no pointer clear is due
  sequence s_quiet;
    !psel && !$past(psel);
  endsequence
  property p_answer; s_setup |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_excl; !(fifo_full && fifo_empty); endproperty
  property p_empty_ae; fifo_empty |-> almost_empty_flag; endproperty
  property p_full_af; fifo_full |-> almost_full_flag; endproperty
  property p_no_push; fifo_full && wen && !ren ##0 s_quiet |=> fifo_full; endproperty
  property p_no_pop; fifo_empty && ren && !wen ##0 s_quiet |=> fifo_empty; endproperty
  property p_load; $rose(load_select) && !load_busy |-> ##[1:6] load_busy; endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  a_one: assert property (p_one) else $error("ready held two cycles");
  a_err: assert property (p_err) else $error("error without ready");
  a_excl: assert property (p_excl) else $error("full and empty together");
  a_empty_ae: assert property (p_empty_ae) else $error("empty not almost empty");
  a_full_af: assert property (p_full_af) else $error("full not almost full");
  a_no_push: assert property (p_no_push) else $error("push taken when full");
  a_no_pop: assert property (p_no_pop) else $error("pop taken when empty");
  a_load: assert property (p_load) else $error("load never started");
endmodule

// ==== verification/esf_loader_model.sv ====
// Serial loader of the fabric user logic behind the test port macro.
// Assumes it shares pclk with the block; pins move on pclk edges only.
`timescale 1ns/1ns
module esf_loader_model #(
  parameter int HOLD = 3  // Cycles each level stands; larger is slower
) (
  // Clock
  input wire logic pclk,
  // Loader pins
  output logic     sel,
  output logic     lclk,
  output logic     ldata
);
  logic [17:0] img [256];  // One block only; bigger images cascade models
  initial begin
    sel   = 1'b0;
    lclk  = 1'b0;
    ldata = 1'b0;
  end
  // Whole image, MSB first, words ascending; a short load would abort
  task automatic run();
    sel <= 1'b1;
    repeat (HOLD) @(posedge pclk);
    for (int i = 0; i < 256; i++) begin
      for (int b = 17; b >= 0; b--) begin
        ldata <= img[i][b];
        repeat (HOLD) @(posedge pclk);
        lclk <= 1'b1;
        repeat (HOLD) @(posedge pclk);
        lclk <= 1'b0;
      end
    end
    repeat (HOLD) @(posedge pclk);
    sel   <= 1'b0;
    ldata <= ~ldata;  // Released line shows no stale bit
  endtask
endmodule

// ==== verification/tb_esf_top.sv ====
// Self-checking bench for esf_top: registers, RAM, FIFO and serial load.
// Assumes esf_checker and esf_loader_model are compiled before it.
`timescale 1ns/1ns
module tb_esf_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        wen, ren, fifo_empty, fifo_full, almost_empty_flag, almost_full_flag;
  logic        load_select, load_clk, load_data, load_busy, irq;
  logic [11:0] paddr, waddr, read_address_bus, a;
  logic [31:0] pwdata, prdata, q, q0;
  logic [17:0] wdata, rdata, d;
  logic [17:0] exp_q [$];  // Words pushed and not yet popped
  int          n_mismatch, n_compared;
  esf_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .wen, .waddr, .wdata, .ren, .read_address_bus, .rdata,
    .fifo_empty, .fifo_full, .almost_empty_flag, .almost_full_flag, .load_select,
    .load_clk, .load_data, .load_busy, .irq);
  esf_loader_model ldr (.pclk, .sel(load_select), .lclk(load_clk), .ldata(load_data));
  // Clock of 10 ns
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Element mask for a width code
  function automatic logic [17:0] msk(input int w);
    return (w == 4) ? 18'h3FFFF : (w == 3) ? 18'h001FF : 18'((1 << (1 << w)) - 1);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus transfer; waits for ready, then idles so irq lag settles
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  // One write or push; e low drives the bus with the enable off
  task automatic put(input logic e, input logic [11:0] ad, input logic [17:0] wd);
    wen   <= e;
    waddr <= ad;
    wdata <= wd;
    @(posedge pclk);
    wen   <= 1'b0;
    @(posedge pclk);
  endtask
  // One read or pop; q0 is rdata one edge after the request, q after p+1
  task automatic get(input logic [11:0] ad, input int p);
    ren              <= 1'b1;
    read_address_bus <= ad;
    @(posedge pclk);
    ren <= 1'b0;
    @(posedge pclk);
    q0 = 32'(rdata);
    if (p != 0) @(posedge pclk);
    q = 32'(rdata);
  endtask
  task automatic flags(input int n);
    chk("flags", {n == 0, n == 256, n <= 2, n >= 254},
        {fifo_empty, fifo_full, almost_empty_flag, almost_full_flag});
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard well beyond the expected run of about 30k cycles
  initial begin
    repeat (80000) @(posedge pclk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, wen, ren} = '0;
    {paddr, waddr, read_address_bus, pwdata, wdata} = '0;
    void'($urandom(62172));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    flags(0);
    apb(0, 12'h000, 0);
    chk("ctrl", 0, q);
    apb(0, 12'h004, 0);
    chk("ae thr", 4, q);
    apb(0, 12'h008, 0);
    chk("af thr", 32'hFC, q);
    apb(0, 12'h00C, 0);
    chk("status", 32'h5, q);
    apb(0, 12'h010, 0);
    chk("events", 0, q);
    apb(1, 12'h018, 32'hFFFF);
    apb(0, 12'h018, 0);
    chk("unmapped", 1, {q[30:0], err});
    // Plain and pipelined reads at each width; a disabled write must not land
    for (int p = 0; p < 2; p++) begin
      for (int w = 0; w < 5; w++) begin
        apb(1, 12'h000, 32'((w << 5) | (w << 2) | (p << 1)));
        a = 12'($urandom_range((4096 >> w) - 1));
        d = 18'($urandom) & msk(w);
        put(1'b1, a, d);
        put(1'b0, a, ~d);
        get(a, p);
        chk("rdata", 32'(d), q);
        put(1'b1, a, ~d & msk(w));
        get(a, p);
        if (p != 0) chk("early rdata", 32'(d), q0);
        chk("rdata", 32'(~d & msk(w)), q);
      end
    end
    // Written four bits wide, read back one bit at a time
    apb(1, 12'h000, 32'h08);
    a = 12'($urandom_range(1023));
    d = 18'($urandom) & 18'h0000F;
    put(1'b1, a, d);
    for (int i = 0; i < 4; i++) begin
      get({a[9:0], 2'(i)}, 0);
      chk("bit read", 32'(d[i]), q);
    end
    // FIFO filled past full, then drained past empty
    apb(1, 12'h000, 32'h91);
    apb(1, 12'h004, 2);
    apb(1, 12'h008, 254);
    apb(1, 12'h014, 32'h7F);
    apb(1, 12'h010, 32'h7F);
    for (int n = 1; n <= 257; n++) begin
      d = 18'($urandom);
      put(1'b1, 12'h000, d);
      if (n <= 256) exp_q.push_back(d);
      flags(exp_q.size());
    end
    apb(0, 12'h00C, 0);
    chk("status", 32'h1000A, q);
    apb(0, 12'h010, 0);
    chk("events", 32'h1A, q);
    chk("irq", 1, irq);
    apb(1, 12'h010, 32'h1A);
    chk("irq", 0, irq);
    apb(1, 12'h014, 0);
    put(1'b1, 12'h000, 0);
    apb(0, 12'h010, 0);
    chk("events", 32'h10, q);
    chk("irq", 0, irq);
    apb(1, 12'h014, 32'h10);
    chk("irq", 1, irq);
    apb(1, 12'h010, 32'h10);
    for (int n = 255; n >= -1; n--) begin
      get(12'h000, 0);
      if (n >= 0) chk("pop", 32'(exp_q.pop_front()), q);
      flags((n < 0) ? 0 : n);
    end
    apb(0, 12'h010, 0);
    chk("events", 32'h25, q);
    apb(1, 12'h010, 32'h7F);
    // Full serial image, then every word read back
    foreach (ldr.img[i]) ldr.img[i] = 18'($urandom);
    ldr.run();
    for (int t = 0; t < 50 && load_busy !== 1'b0; t++) @(posedge pclk);
    chk("busy", 0, load_busy);
    apb(0, 12'h010, 0);
    chk("load event", 32'h40, q & 32'h40);
    apb(1, 12'h000, 32'h90);
    for (int i = 0; i < 256; i++) begin
      get(12'(i), 0);
      chk("loaded word", 32'(ldr.img[i]), q);
    end
    complete_run();
  end
endmodule
bind esf_top esf_checker u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .wen, .ren, .fifo_empty, .fifo_full, .almost_empty_flag, .almost_full_flag,
  .load_select, .load_busy);
